// ===== verilog/bus_sizing_pkg.sv
// Constants, types and register map of the sizing bus master.
// Assumes a single 25 MHz clock and an APB slave port.
package bus_sizing_pkg;

   // Clock and bus monitor timing
   localparam int unsigned CLK_PERIOD_NS = 40;
   localparam int unsigned MON_TIME_NS   = 10240;
   localparam int unsigned MON_CYCLES    = MON_TIME_NS / CLK_PERIOD_NS;
   localparam int unsigned MON_W         = 9;
   // Wait cycles before an internal end, so read data clears the synchroniser
   localparam int unsigned SYNC_CYC      = 2;

   // Register byte offsets
   localparam logic [7:0] OFF_CTRL   = 8'h00;
   localparam logic [7:0] OFF_ADDR   = 8'h04;
   localparam logic [7:0] OFF_WDATA  = 8'h08;
   localparam logic [7:0] OFF_RDATA  = 8'h0C;
   localparam logic [7:0] OFF_STATUS = 8'h10;
   localparam logic [7:0] OFF_CONFIG = 8'h14;
   localparam logic [7:0] OFF_PINS   = 8'h18;

   // Control fields
   localparam int unsigned CTRL_START = 0;
   localparam int unsigned CTRL_READ  = 1;
   localparam int unsigned CTRL_SIZE  = 2;
   localparam int unsigned CTRL_IACK  = 4;

   // Status fields
   localparam int unsigned STAT_BUSY  = 0;
   localparam int unsigned STAT_DONE  = 1;
   localparam int unsigned STAT_FAULT = 2;
   localparam int unsigned STAT_AUTO_VECTOR_TERM  = 3;
   localparam int unsigned STAT_RETRY = 4;
   localparam int unsigned STAT_W     = 5;

   // Configuration fields
   localparam int unsigned CFG_WIDE     = 0;
   localparam int unsigned CFG_INT_ACK  = 1;
   localparam int unsigned CFG_FAST     = 2;
   localparam int unsigned CFG_INT_AUTO_VECTOR_TERM = 3;
   localparam int unsigned CFG_PORT     = 4;
   localparam int unsigned CFG_W        = 6;
   localparam logic [CFG_W-1:0] CFG_RST = 6'h01;

   // Pin assignment field
   localparam int unsigned PIN_ADDR_HI = 7;

   // Size codes on the size outputs
   localparam logic [1:0] SIZE_LONG  = 2'h0;
   localparam logic [1:0] SIZE_BYTE  = 2'h1;
   localparam logic [1:0] SIZE_WORD  = 2'h2;
   localparam logic [1:0] SIZE_THREE = 2'h3;
   localparam logic [2:0] REM_LONG   = 3'h4;

   // Acknowledge pair codes {high, low}
   localparam logic [1:0] ACK_WAIT = 2'h3;
   localparam logic [1:0] ACK_8    = 2'h2;
   localparam logic [1:0] ACK_16   = 2'h1;
   localparam logic [1:0] ACK_32   = 2'h0;

   typedef enum logic [4:0]
   {
      CY_IDLE   = 5'h01,
      CY_SETUP  = 5'h02,
      CY_STROBE = 5'h04,
      CY_WAIT   = 5'h08,
      CY_END    = 5'h10
   } cyc_state_t;

   // Termination pins, pin levels (active low)
   typedef struct packed
   {
      logic ack_high;
      logic ack_low;
      logic fault;
      logic halt;
      logic auto_vector_term;
   } term_t;

endpackage

// ===== verilog/bus_sizing_master.sv
// Bus master cycle logic: strobes, byte-lane write enables, cycle
// termination and dynamic bus sizing with operand byte steering.
// Assumes APB software access on the same clock; bus pins asynchronous.
//
// The register offsets and the APB register port were chosen for this implementation.
`timescale 1ns/1ns
module bus_sizing_master
   import bus_sizing_pkg::*;
(
   // Clock and reset
   input  wire logic        clock,
   input  wire logic        resetn,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // Bus outputs
   output logic      [31:0] address_out,
   output logic             size_code_1,
   output logic             size_code_0,
   output logic             read_write,
   output logic             address_valid_strobe_n,
   output logic             data_valid_strobe_n,
   output logic             read_output_enable_n,
   output logic             byte_lane_write_enable_0_n,
   output logic             byte_lane_write_enable_1_n,
   output logic             byte_lane_write_enable_2_n,
   output logic             byte_lane_write_enable_3_n,
   // Data bus, three signals
   input  wire logic [31:0] data_in,
   output logic      [31:0] data_out,
   output logic             data_oe_n,
   // Termination inputs
   input  wire logic        transfer_ack_high_n,
   input  wire logic        transfer_ack_low_n,
   input  wire logic        bus_fault_term_n,
   input  wire logic        halt_n,
   input  wire logic        auto_vector_term_n
);

   cyc_state_t        state_r, state_nxt;
   term_t             term_s1_r, term_s2_r;
   logic [31:0]       din_s1_r, din_s2_r;
   logic [31:0]       addr_r, wdata_r, rdata_r, rdata_nxt, dout_r;
   logic [CFG_W-1:0]  cfg_r;
   logic              pin_hi_r;
   logic [STAT_W-1:1] stat_r;
   logic [1:0]        opsize_r;
   logic              rd_r, iack_r, as_r, ds_r, again_r, retry_r;
   logic [2:0]        rem_r, moved_r;
   logic [MON_W-1:0]  mon_r;

   // APB decode
   wire acc      = psel && penable;
   wire wr_en    = acc && pwrite;
   wire hit_ctrl = paddr == OFF_CTRL;
   wire hit_addr = paddr == OFF_ADDR;
   wire hit_wdat = paddr == OFF_WDATA;
   wire hit_rdat = paddr == OFF_RDATA;
   wire hit_stat = paddr == OFF_STATUS;
   wire hit_cfg  = paddr == OFF_CONFIG;
   wire hit_pins = paddr == OFF_PINS;
   wire mapped   = hit_ctrl || hit_addr || hit_wdat || hit_rdat
                   || hit_stat || hit_cfg || hit_pins;
   wire idle     = state_r == CY_IDLE;
   // A start while busy is dropped; software polls the busy bit
   wire start    = wr_en && hit_ctrl && pwdata[CTRL_START] && idle;

   assign pready  = 1'b1;
   assign pslverr = acc && !mapped;

   always_comb
   begin
      prdata = 32'h0000_0000;
      if (hit_ctrl)
         prdata = {27'h0, iack_r, opsize_r, rd_r, 1'b0};
      else if (hit_addr)
         prdata = addr_r;
      else if (hit_wdat)
         prdata = wdata_r;
      else if (hit_rdat)
         prdata = rdata_r;
      else if (hit_stat)
         prdata = {27'h0, stat_r, !idle};
      else if (hit_cfg)
         prdata = {26'h0, cfg_r};
      else if (hit_pins)
         prdata = {24'h0, pin_hi_r, 7'h0};
   end

   // Two-flop synchronisers for every bus input
   always_ff @(posedge clock)
   begin
      term_s1_r <= '{transfer_ack_high_n, transfer_ack_low_n,
                     bus_fault_term_n, halt_n, auto_vector_term_n};
      term_s2_r <= term_s1_r;
      din_s1_r  <= data_in;
      din_s2_r  <= din_s1_r;
   end

   // Termination decode
   wire       wide     = cfg_r[CFG_WIDE];
   wire [1:0] int_port = cfg_r[CFG_PORT +: 2];
   wire       fast     = cfg_r[CFG_FAST];
   wire [1:0] ack_code = (cfg_r[CFG_INT_ACK] || fast) ? int_port
                         : {term_s2_r.ack_high, term_s2_r.ack_low};
   wire int_term = cfg_r[CFG_INT_ACK] || fast;
   // Internal ends wait out the data synchroniser latency
   wire sync_ok  = mon_r >= MON_W'(SYNC_CYC);
   wire ack_done = ack_code != ACK_WAIT
                   && (!int_term || sync_ok);
   wire mon_out  = mon_r == MON_W'(MON_CYCLES - 1);
   wire fault    = !term_s2_r.fault || mon_out;
   wire halt     = !term_s2_r.halt;
   wire auto_vector_term     = iack_r && (!term_s2_r.auto_vector_term
                   || cfg_r[CFG_INT_AUTO_VECTOR_TERM]);
   wire do_retry = fault && halt;
   wire ends     = fault || auto_vector_term || ack_done;

   // Bytes moved this cycle from port width and offset
   wire [2:0] cap = (ack_code == ACK_32) ? 3'h4 - {1'b0, addr_r[1:0]}
                  : (ack_code == ACK_16) ? 3'h2 - {2'h0, addr_r[0]}
                  : 3'h1;
   wire [2:0] moved = (cap < rem_r) ? cap : rem_r;
   wire [1:0] lane_base = (ack_code == ACK_32) ? addr_r[1:0]
                        : (ack_code == ACK_16) ? {1'b0, addr_r[0]}
                        : 2'h0;
   // First operand byte still owed
   wire [1:0] first = 2'(3'h4 - rem_r);

   // Read steering: moved bytes from their lanes into the operand
   always_comb
   begin
      logic [1:0] op_i;
      logic [1:0] ln_i;
      op_i = 2'h0;
      ln_i = 2'h0;
      rdata_nxt = rdata_r;
      for (int j = 0; j < 4; j++)
      begin
         op_i = 2'(first + 2'(j));
         ln_i = 2'(lane_base + 2'(j));
         if (3'(j) < moved)
            rdata_nxt[8*(3-op_i) +: 8] = din_s2_r[8*(3-ln_i) +: 8];
      end
   end

   // Write steering: each lane picks an operand byte
   logic [31:0] wmux;
   always_comb
   begin
      logic [1:0] off;
      logic [2:0] d;
      logic [2:0] idx;
      off  = addr_r[1:0];
      d    = 3'h0;
      idx  = 3'h0;
      wmux = 32'h0000_0000;
      for (int k = 0; k < 4; k++)
      begin
         if (2'(k) >= off)
            d = 3'(k) - {1'b0, off};
         else if (k == 1)
            d = {2'h0, !off[0]};
         else if (k == 2)
            d = 3'h1;
         else
            d = 3'h0;
         idx = {1'b0, first} + d;
         if (idx > 3'h3)
            idx = 3'h3;
         wmux[8*(3-k) +: 8] = wdata_r[8*(3-idx[1:0]) +: 8];
      end
   end

   // Cycle sequencer
   always_comb
   begin
      case (state_r)
         CY_IDLE:   state_nxt = start ? CY_SETUP : CY_IDLE;
         CY_SETUP:  state_nxt = CY_STROBE;
         CY_STROBE: state_nxt = CY_WAIT;
         CY_WAIT:   state_nxt = ends ? CY_END : CY_WAIT;
         CY_END:    state_nxt = again_r ? CY_SETUP : CY_IDLE;
         default:   state_nxt = CY_IDLE;
      endcase
   end

   wire term_now = state_r == CY_WAIT && ends;
   wire fin_ok   = term_now && !fault && !auto_vector_term && moved == rem_r;
   wire fin_bad  = term_now && !do_retry && (fault || auto_vector_term);
   wire done_set = term_now && !do_retry && (fin_ok || fin_bad);

   always_ff @(posedge clock)
   begin
      if (!resetn)
         state_r <= CY_IDLE;
      else
         state_r <= state_nxt;
   end

   // Strobes from flops; data strobe lags by one clock on writes
   always_ff @(posedge clock)
   begin
      if (!resetn)
      begin
         as_r <= 1'b0;
         ds_r <= 1'b0;
      end
      else
      begin
         as_r <= state_nxt == CY_STROBE || state_nxt == CY_WAIT;
         ds_r <= (state_nxt == CY_STROBE && rd_r)
                 || state_nxt == CY_WAIT;
      end
   end

   // Operand bookkeeping
   always_ff @(posedge clock)
   begin
      if (!resetn)
      begin
         rem_r   <= 3'h0;
         again_r <= 1'b0;
         retry_r <= 1'b0;
         moved_r <= 3'h0;
         mon_r   <= '0;
      end
      else if (start)
      begin
         rem_r <= (pwdata[CTRL_SIZE +: 2] == SIZE_LONG) ? REM_LONG
                  : {1'b0, pwdata[CTRL_SIZE +: 2]};
      end
      else if (term_now)
      begin
         retry_r <= do_retry;
         moved_r <= moved;
         again_r <= do_retry || !(fin_ok || fin_bad);
         if (!do_retry && !fault && !auto_vector_term)
            rem_r <= rem_r - moved;
      end
      mon_r <= (state_r == CY_WAIT && !ends) ? mon_r + 1'b1 : '0;
   end

   // Software registers and sticky status; set beats clear
   always_ff @(posedge clock)
   begin
      if (!resetn)
      begin
         addr_r   <= 32'h0000_0000;
         wdata_r  <= 32'h0000_0000;
         rdata_r  <= 32'h0000_0000;
         cfg_r    <= CFG_RST;
         pin_hi_r <= 1'b0;
         opsize_r <= SIZE_LONG;
         rd_r     <= 1'b0;
         iack_r   <= 1'b0;
         stat_r   <= '0;
      end
      else
      begin
         if (wr_en && hit_addr && idle)
            addr_r <= pwdata;
         if (wr_en && hit_wdat && idle)
            wdata_r <= pwdata;
         if (wr_en && hit_cfg && idle)
            cfg_r <= pwdata[CFG_W-1:0];
         if (wr_en && hit_pins && idle)
            pin_hi_r <= pwdata[PIN_ADDR_HI];
         if (start)
         begin
            opsize_r <= pwdata[CTRL_SIZE +: 2];
            rd_r     <= pwdata[CTRL_READ];
            iack_r   <= pwdata[CTRL_IACK];
         end
         if (term_now && !do_retry && !fault && !auto_vector_term)
         begin
            addr_r <= addr_r + {29'h0, moved};
            if (rd_r)
               rdata_r <= rdata_nxt;
         end
         stat_r <= (wr_en && hit_stat) ? stat_r & ~pwdata[STAT_W-1:1]
                                       : stat_r;
         if (done_set)
            stat_r[STAT_DONE] <= 1'b1;
         if (fin_bad && fault)
            stat_r[STAT_FAULT] <= 1'b1;
         if (fin_bad && !fault)
            stat_r[STAT_AUTO_VECTOR_TERM] <= 1'b1;
         if (term_now && do_retry)
            stat_r[STAT_RETRY] <= 1'b1;
      end
   end

   // Write data latched at cycle setup; all 32 lines driven
   always_ff @(posedge clock)
   begin
      if (!resetn)
         dout_r <= 32'h0000_0000;
      else if (state_r == CY_SETUP)
         dout_r <= wmux;
   end

   // Pins
   wire a0 = addr_r[0];
   wire a1 = addr_r[1];
   wire s0 = rem_r[0];
   wire s1 = rem_r[1];
   wire off_n = rd_r || !as_r;
   wire pin_hi = !wide && pin_hi_r;

   assign address_out = addr_r;
   assign size_code_1 = s1;
   assign size_code_0 = s0;
   assign read_write  = rd_r;
   assign address_valid_strobe_n = !as_r;
   assign data_valid_strobe_n    = !ds_r;
   assign read_output_enable_n   = !(as_r && rd_r);
   assign data_out  = dout_r;
   assign data_oe_n = rd_r || idle;

   // Lane enables from address, size, direction and address strobe; lanes 2 and 3 give addr_r[29] and addr_r[28] when pin_hi
   assign byte_lane_write_enable_0_n = wide
      ? (off_n || a0 || a1)
      : (off_n || a0);
   assign byte_lane_write_enable_1_n = wide
      ? (off_n || !((!a1 && !s0) || (a0 && !a1) || (!a1 && s1)))
      : (off_n || (!a0 && s0 && !s1));
   assign byte_lane_write_enable_2_n = pin_hi ? addr_r[29]
      : !wide || off_n || !((!a0 && a1) || (!a1 && !s0 && !s1));
   assign byte_lane_write_enable_3_n = pin_hi ? addr_r[28]
      : !wide || off_n || !((a0 && !s0 && !s1) || (!s0 && !s1)
                            || (a0 && !a1) || (!a1 && !s1));

   // Checks
   a_read_ds_with_as: assert property (@(posedge clock) disable iff (!resetn)
      ($fell(address_valid_strobe_n) && rd_r) |-> !data_valid_strobe_n)
      else $error("read data strobe not with address strobe");
   a_write_ds_lag: assert property (@(posedge clock) disable iff (!resetn)
      ($fell(address_valid_strobe_n) && !rd_r)
      |-> data_valid_strobe_n ##1 !data_valid_strobe_n)
      else $error("write data strobe not one clock late");
   a_oe_read_only: assert property (@(posedge clock) disable iff (!resetn)
      !read_output_enable_n |-> rd_r && !address_valid_strobe_n)
      else $error("output enable outside read strobe");
   a_we_with_as: assert property (@(posedge clock) disable iff (!resetn)
      (address_valid_strobe_n || rd_r) && wide |->
      byte_lane_write_enable_0_n && byte_lane_write_enable_1_n)
      else $error("write enable outside write strobe");
   a_we0_aligned: assert property (@(posedge clock) disable iff (!resetn)
      (wide && !byte_lane_write_enable_0_n) |-> address_out[1:0] == 2'h0)
      else $error("lane 0 enable on unaligned address");
   a_first_long: assert property (@(posedge clock) disable iff (!resetn)
      (start && pwdata[CTRL_SIZE +: 2] == SIZE_LONG) |->
      ##2 {size_code_1, size_code_0} == SIZE_LONG)
      else $error("long operand not attempted whole");
   a_retry_same: assert property (@(posedge clock) disable iff (!resetn)
      (term_now && do_retry) |=> $stable(address_out) && $stable(rem_r))
      else $error("retry moved the address");
   a_partial_advance: assert property (@(posedge clock) disable iff (!resetn)
      (state_r == CY_END && again_r && !retry_r) |->
      address_out == $past(address_out, 1) + {29'h0, moved_r}
      ##2 !address_valid_strobe_n)
      else $error("partial cycle not rerun");
   a_auto_vector_term_ignored: assert property (@(posedge clock) disable iff (!resetn)
      !iack_r |-> !stat_r[STAT_AUTO_VECTOR_TERM] || $stable(stat_r[STAT_AUTO_VECTOR_TERM]))
      else $error("autovector taken outside acknowledge");
   a_write_drive: assert property (@(posedge clock) disable iff (!resetn)
      (!rd_r && !address_valid_strobe_n) |-> !data_oe_n)
      else $error("write data not driven");

   c_read_done: cover property (@(posedge clock) done_set && rd_r);
   c_multi_cycle: cover property (@(posedge clock)
      term_now && moved != rem_r && !fault);
   c_retry: cover property (@(posedge clock) term_now && do_retry);
   c_fault: cover property (@(posedge clock) fin_bad && fault);

endmodule

// ===== dv/bus_slave_model.sv
// Behavioural slave: fixed port width, answers after a set delay.
// Assumes active-low strobes and pull-ups on termination lines.
`timescale 1ns/1ns
module bus_slave_model
   import bus_sizing_pkg::*;
(
   // Clock
   input  wire logic        clock,
   // Bus side
   input  wire logic [31:0] address_out,
   input  wire logic        read_write,
   input  wire logic        address_valid_strobe_n,
   output logic      [31:0] data_in,
   output term_t            term_n,
   // Bench control
   input  wire logic [1:0]  port,
   input  wire logic [2:0]  mode,
   input  wire logic [1:0]  dly
);
   logic [2:0] cnt_r;
   logic       tried_r;

   function automatic logic [7:0] mem(input logic [31:0] m);
      return m[7:0] ^ m[15:8] ^ 8'h5A;
   endfunction

   // Unused lanes carry junk, never a copy
   function automatic logic [31:0] lanes(input logic [31:0] a);
      logic [31:0] l;
      l = {a[31:2], 2'h0};
      if (port == ACK_32)
         return {mem(l), mem(l + 1), mem(l + 2), mem(l + 3)};
      l = {a[31:1], 1'b0};
      if (port == ACK_16)
         return {mem(l), mem(l + 1), 16'h0F0F};
      return {mem(a), 24'hC3C3C3};
   endfunction

   initial
   begin
      data_in = 32'h0;
      term_n  = '1;
      cnt_r   = 3'h0;
      tried_r = 1'b0;
   end

   always @(posedge clock)
   begin
      data_in <= ~data_in;
      if (address_valid_strobe_n)
      begin
         cnt_r  <= 3'h0;
         term_n <= '1;
         if (mode != 3'h2)
            tried_r <= 1'b0;
      end
      else
      begin
         if (cnt_r <= {1'b0, dly})
            cnt_r <= cnt_r + 3'h1;
         if (read_write)
            data_in <= lanes(address_out);
         if (cnt_r == {1'b0, dly})
            case (mode)
               3'h0: {term_n.ack_high, term_n.ack_low} <= port;
               3'h1: term_n.fault <= 1'b0;
               3'h2:
               begin
                  if (tried_r)
                     {term_n.ack_high, term_n.ack_low} <= port;
                  else
                     {term_n.fault, term_n.halt} <= 2'h0;
                  tried_r <= 1'b1;
               end
               3'h3: term_n.auto_vector_term <= 1'b0;
               default: ;
            endcase
      end
   end
endmodule

// ===== dv/bus_sizing_master_tb_top.sv
// Bench of the sizing bus master against a behavioural slave.
// Assumes the package register map and a zero-wait APB slave.
`timescale 1ns/1ns
`define check(g, e) \
   begin \
      tests_run++; \
      if ((g) !== (e)) \
      begin \
         error_cnt++; \
         $display("unexpected at %0t: %h vs %h", $time, g, e); \
      end \
   end
module bus_sizing_master_tb_top
   import bus_sizing_pkg::*;
   ;
   logic        clock, resetn, psel, penable, pwrite, pready, pslverr;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, address_out, data_in;
   logic        size_code_1, size_code_0, read_write, as_n, ds_n, oe_n;
   logic [3:0]  we_n;
   logic        data_oe_n, as_q, wide, pin;
   term_t       term_n;
   logic [1:0]  port, dly;
   logic [2:0]  mode;
   logic [33:0] exq[$];
   logic [33:0] e34;
   logic [63:0] e64;
   logic [31:0] dout, wd;
   logic [3:0]  tab[4] = '{4'h3, 4'h9, 4'h5, 4'h3};
   int          error_cnt, tests_run;

   bus_sizing_master i_dut
   (
      .clock(clock), .resetn(resetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .address_out(address_out),
      .size_code_1(size_code_1), .size_code_0(size_code_0),
      .read_write(read_write), .address_valid_strobe_n(as_n),
      .data_valid_strobe_n(ds_n), .read_output_enable_n(oe_n),
      .byte_lane_write_enable_0_n(we_n[3]),
      .byte_lane_write_enable_1_n(we_n[2]),
      .byte_lane_write_enable_2_n(we_n[1]),
      .byte_lane_write_enable_3_n(we_n[0]),
      .data_in(data_in), .data_out(dout), .data_oe_n(data_oe_n),
      .transfer_ack_high_n(term_n.ack_high),
      .transfer_ack_low_n(term_n.ack_low),
      .bus_fault_term_n(term_n.fault), .halt_n(term_n.halt),
      .auto_vector_term_n(term_n.auto_vector_term)
   );

   bus_slave_model i_slave
   (
      .clock(clock), .address_out(address_out), .read_write(read_write),
      .address_valid_strobe_n(as_n), .data_in(data_in), .term_n(term_n),
      .port(port), .mode(mode), .dly(dly)
   );

   function automatic logic [7:0] mem(input logic [31:0] m);
      return m[7:0] ^ m[15:8] ^ 8'h5A;
   endfunction

   function automatic logic [3:0] we_exp();
      logic g, a1, a0, s1, s0;
      {a1, a0} = address_out[1:0];
      {s1, s0} = {size_code_1, size_code_0};
      g = read_write | as_n;
      if (wide)
         return {g | a0 | a1, g | ~((~a1 & ~s0) | (a0 & ~a1) | (~a1 & s1)),
            g | ~((~a0 & a1) | (~a1 & ~s0 & ~s1)),
            g | ~((a0 & ~s0 & ~s1) | (~s0 & ~s1) | (a0 & ~a1) | (~a1 & ~s1))};
      return {g | a0, g | (~a0 & s0 & ~s1),
         pin ? address_out[29:28] : 2'h3};
   endfunction

   // Lane mask and operand bytes the slave latches this write cycle
   function automatic logic [63:0] wr_exp();
      logic [63:0] r;
      logic [2:0]  rem, mv, op, ln, lb;
      r   = '0;
      rem = ({size_code_1, size_code_0} == SIZE_LONG) ? REM_LONG
            : {1'b0, size_code_1, size_code_0};
      mv  = (port == ACK_32) ? 3'h4 - {1'b0, address_out[1:0]} :
         (port == ACK_16) ? 3'h2 - {2'h0, address_out[0]} : 3'h1;
      lb  = (port == ACK_32) ? {1'b0, address_out[1:0]} :
         (port == ACK_16) ? {2'h0, address_out[0]} : 3'h0;
      if (mv > rem)
         mv = rem;
      for (int j = 0; j < 4; j++)
         if (3'(j) < mv)
         begin
            ln = lb + 3'(j);
            op = 3'h4 - rem + 3'(j);
            r[32 + 8*(3-ln[1:0]) +: 8] = 8'hFF;
            r[8*(3-ln[1:0]) +: 8] = wd[8*(3-op[1:0]) +: 8];
         end
      return r;
   endfunction

   task automatic finish_test();
      $display("Checks %0d, mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   task automatic apb(input logic w, input logic [7:0] ad,
      input logic [31:0] d, output logic [31:0] q, output logic e);
      int n;
      n = 0;
      @(posedge clock);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= ad;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      do
      begin
         @(posedge clock);
         n++;
      end
      while (pready !== 1'b1 && n < 20);
      q = prdata;
      e = pslverr;
      `check(n < 20, 1'b1)
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic run_op(input logic [31:0] a, input logic rd,
      input logic [1:0] sz, pc, input logic ia, ck, output logic [31:0] st);
      logic [31:0] q, ea;
      logic        e;
      logic [2:0]  rem, mv;
      int          n;
      ea  = a;
      rem = (sz == SIZE_LONG) ? REM_LONG : {1'b0, sz};
      while (ck && rem != 3'h0)
      begin
         mv = (pc == ACK_32) ? 3'h4 - {1'b0, ea[1:0]} :
            (pc == ACK_16) ? 3'h2 - {2'h0, ea[0]} : 3'h1;
         if (mv > rem)
            mv = rem;
         exq.push_back({ea, rem[1:0]});
         ea  = ea + {29'h0, mv};
         rem = rem - mv;
      end
      apb(1'b1, OFF_ADDR, a, q, e);
      wd = $urandom;
      apb(1'b1, OFF_WDATA, wd, q, e);
      apb(1'b1, OFF_CTRL, {27'h0, ia, sz, rd, 1'b1}, q, e);
      n = 0;
      q[STAT_BUSY] = 1'b1;
      while (q[STAT_BUSY] !== 1'b0 && n < 500)
      begin
         apb(1'b0, OFF_STATUS, 32'h0, q, e);
         n++;
      end
      st = q;
      apb(1'b1, OFF_STATUS, 32'h1F, q, e);
      `check(exq.size() == 0, 1'b1)
      exq.delete();
   endtask

   always @(posedge clock)
   begin
      as_q <= as_n;
      if (resetn)
      begin
         `check(we_n, we_exp())
         `check(oe_n, as_n | ~read_write)
         if (!as_n && read_write)
            `check(ds_n, 1'b0)
         if (!as_n && !read_write)
         begin
            `check(ds_n, as_q)
            `check(data_oe_n, 1'b0)
         end
         if (!as_n && !read_write && !ds_n)
         begin
            e64 = wr_exp();
            `check(dout & e64[63:32], e64[31:0])
         end
         if (as_q && !as_n && exq.size() > 0)
         begin
            e34 = exq.pop_front();
            `check({address_out, size_code_1, size_code_0}, e34)
         end
      end
   end

   initial
   begin
      clock = 1'b0;
      forever
         #20 clock = ~clock;
   end

   initial
   begin
      repeat (60000) @(posedge clock);
      error_cnt++;
      finish_test();
   end

   initial
   begin
      logic [31:0] q, st, a;
      logic [1:0]  pc, sz;
      logic        e, in;
      logic [31:0] r;
      resetn  = 1'b0;
      psel    = 1'b0;
      penable = 1'b0;
      pwrite  = 1'b0;
      paddr   = 8'h00;
      pwdata  = 32'h0;
      wide    = 1'b1;
      pin     = 1'b0;
      port    = ACK_32;
      mode    = 3'h0;
      dly     = 2'h0;
      void'($urandom(32624));
      repeat (4) @(posedge clock);
      resetn <= 1'b1;
      `check({as_n, ds_n, we_n, data_oe_n}, 7'h7F)
      apb(1'b0, OFF_CONFIG, 32'h0, q, e);
      `check(q[CFG_W-1:0], CFG_RST)
      apb(1'b0, 8'h1C, 32'h0, q, e);
      `check(e, 1'b1)
      for (int i = 0; i < 48; i++)
      begin
         r  = $urandom;
         a  = $urandom;
         pc = (r[1:0] == ACK_WAIT) ? ACK_32 : r[1:0];
         sz = r[12:11];
         in = r[2] & r[3];
         if (i < 4)
         begin
            a[1:0] = i[1:0];
            pc     = ACK_8;
            sz     = SIZE_LONG;
         end
         apb(1'b1, OFF_CONFIG, {26'h0, pc, 1'b0, in & r[4], in & ~r[4],
            r[5]}, q, e);
         wide <= r[5];
         apb(1'b1, OFF_PINS, {24'h0, r[6], 7'h0}, q, e);
         pin  <= r[6];
         port <= pc;
         dly  <= r[9:8];
         mode <= in ? 3'h4 : 3'h0;
         run_op(a, r[10], sz, pc, 1'b0, 1'b1, st);
         `check(st[4:0], 5'h02)
         if (r[10] && sz == SIZE_LONG)
         begin
            apb(1'b0, OFF_RDATA, 32'h0, q, e);
            `check(q, {mem(a), mem(a + 1), mem(a + 2), mem(a + 3)})
         end
      end
      // Fault, retry, autovector taken, autovector ignored
      apb(1'b1, OFF_CONFIG, 32'h1, q, e);
      wide <= 1'b1;
      for (int i = 0; i < 4; i++)
      begin
         mode <= (i == 0) ? 3'h1 : (i == 1) ? 3'h2 : 3'h3;
         port <= ACK_16;
         dly  <= 2'h1;
         run_op(32'h100, i[0], SIZE_LONG, ACK_16, i == 2, 1'b0, st);
         `check(st[4:1], tab[i])
      end
      finish_test();
   end
endmodule
